//--- rtl/pao_defs.vh
// constants for the pipelined converter output port
`ifndef PAO_DEFS_VH
`define PAO_DEFS_VH
`define PAO_WIDTH        14
`define PAO_LATENCY      10
`define PAO_MIDSCALE     14'h2000
`define PAO_MSB_POS      13
`define PAO_LSB_POS      0
`define PAO_RESET_WORD   14'h0000
`endif

//--- rtl/pao_port.v
// digital output side of a pipelined 14-bit sampling converter
// Function
// - each convert clock rising edge outside sleep starts sample
// - result appears ten convert cycles later
// - one 14-bit word, offset or twos complement
// - select high gives twos complement coding
// - enable high floats data outputs
// - sleep request high powers converter down
// - valid strobe marks valid output word
// - first line msb, last line lsb
// - complementary input inverts code orientation
// - unconnected control inputs read low
`timescale 1ns/1ps
`default_nettype none
`include "pao_defs.vh"
module pao_port (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // convert clock pin and digitised sample (signed, true minus complement)
  input  wire        i_convert_clock,
  input  wire [13:0] i_sample_true,
  input  wire [13:0] i_sample_comp,
  input  wire        i_invert_input,
  // static control pins
  input  wire        i_twos_comp_select,
  input  wire        i_out_enable_n,
  input  wire        i_sleep_request,
  // parallel output word
  output reg  [13:0] o_data,
  output reg  [13:0] o_data_oe,
  output reg         o_sample_valid_strobe,
  output reg         o_powered_down
);

  // convert clock synchroniser and edge history
  reg                    cclk_s1_q;
  reg                    cclk_s2_q;
  reg                    cclk_prev_q;
  // control pin synchronisers
  reg                    sel_s1_q;
  reg                    sel_s2_q;
  reg                    oe_s1_q;
  reg                    oe_s2_q;
  reg                    pd_s1_q;
  reg                    pd_s2_q;
  // sample pipeline and its valid marks
  reg [13:0]             pipe_q [0:`PAO_LATENCY-1];
  reg [`PAO_LATENCY-1:0] vpipe_q;
  reg [`PAO_LATENCY-1:0] vpipe_d;
  // next values of the output flops
  reg [13:0]             code_d;
  reg [13:0]             data_d;
  reg [13:0]             data_oe_d;
  reg                    strobe_d;
  reg                    powered_down_d;
  // edge detection and input differences
  wire                   start_edge;
  wire                   advance;
  wire [13:0]            diff_true;
  wire [13:0]            diff_comp;
  integer                k;

  // code from signed difference; msb inversion yields offset binary
  function [13:0] pao_code;
    input [13:0] diff;
    input        twos;
    begin
      pao_code = twos ? diff : (diff ^ `PAO_MIDSCALE);
    end
  endfunction

  // enable word for the data lines; high request floats them
  function [13:0] pao_oe_word;
    input float_req;
    begin
      pao_oe_word = float_req ? 14'h0000 : 14'h3fff;
    end
  endfunction

  assign diff_true  = i_sample_true - i_sample_comp;
  assign diff_comp  = i_sample_comp - i_sample_true;
  assign start_edge = cclk_s2_q & ~cclk_prev_q;
  assign advance    = start_edge & ~pd_s2_q;

  // convert clock pin: two sync flops, then the edge history flop
  always @(posedge i_clock) begin
    if (i_rst) begin
      cclk_s1_q   <= 1'b0;
      cclk_s2_q   <= 1'b0;
      cclk_prev_q <= 1'b0;
    end else begin
      cclk_s1_q   <= i_convert_clock;
      cclk_s2_q   <= cclk_s1_q;
      cclk_prev_q <= cclk_s2_q;
    end
  end

  // coding select pin; reset low as with its pull-down
  always @(posedge i_clock) begin
    if (i_rst) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end else begin
      sel_s1_q <= i_twos_comp_select;
      sel_s2_q <= sel_s1_q;
    end
  end

  // output enable pin; reset low as with its pull-down
  always @(posedge i_clock) begin
    if (i_rst) begin
      oe_s1_q <= 1'b0;
      oe_s2_q <= 1'b0;
    end else begin
      oe_s1_q <= i_out_enable_n;
      oe_s2_q <= oe_s1_q;
    end
  end

  // sleep request pin; reset low as with its pull-down
  always @(posedge i_clock) begin
    if (i_rst) begin
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
    end else begin
      pd_s1_q <= i_sleep_request;
      pd_s2_q <= pd_s1_q;
    end
  end

  // code of the current input, orientation set by the input in use
  always @* begin
    if (i_invert_input) begin
      code_d = pao_code(diff_comp, sel_s2_q);
    end else begin
      code_d = pao_code(diff_true, sel_s2_q);
    end
  end

  // valid marks: cleared while asleep, shifted on each taken edge
  always @* begin
    if (pd_s2_q) begin
      vpipe_d = {`PAO_LATENCY{1'b0}};
    end else if (advance) begin
      vpipe_d = {vpipe_q[`PAO_LATENCY-2:0], 1'b1};
    end else begin
      vpipe_d = vpipe_q;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      vpipe_q <= {`PAO_LATENCY{1'b0}};
    end else begin
      vpipe_q <= vpipe_d;
    end
  end

  // sample words, one stage per taken edge
  always @(posedge i_clock) begin
    if (i_rst) begin
      for (k = 0; k < `PAO_LATENCY; k = k + 1) begin
        pipe_q[k] <= `PAO_RESET_WORD;
      end
    end else if (advance) begin
      pipe_q[0] <= code_d;
      for (k = 1; k < `PAO_LATENCY; k = k + 1) begin
        pipe_q[k] <= pipe_q[k-1];
      end
    end
  end

  // next output values; word loads and strobe pulses only on a taken edge
  always @* begin
    data_d         = o_data;
    strobe_d       = 1'b0;
    data_oe_d      = pao_oe_word(oe_s2_q);
    powered_down_d = pd_s2_q;
    if (advance) begin
      // word started ten edges ago leaves now
      data_d   = pipe_q[`PAO_LATENCY-1];
      strobe_d = vpipe_q[`PAO_LATENCY-1];
    end
  end

  // output flops; lines float during reset
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_data                <= `PAO_RESET_WORD;
      o_data_oe             <= pao_oe_word(1'b1);
      o_sample_valid_strobe <= 1'b0;
      o_powered_down        <= 1'b0;
    end else begin
      o_data                <= data_d;
      o_data_oe             <= data_oe_d;
      o_sample_valid_strobe <= strobe_d;
      o_powered_down        <= powered_down_d;
    end
  end

endmodule // pao_port
`default_nettype wire

//--- testbench/pao_capture.sv
// capture model latching each valid word
`timescale 1ns/1ps
`default_nettype none
module pao_capture (
  input  wire logic        i_clock,
  input  wire logic        o_sample_valid_strobe,
  input  wire logic [13:0] o_data,
  output var  logic [13:0] w
);
  always @(posedge i_clock) if (o_sample_valid_strobe) w <= o_data;
endmodule // pao_capture
`default_nettype wire

//--- testbench/pao_port_asserts.sv
// port checker
`timescale 1ns/1ps
`default_nettype none
module pao_port_asserts (
  input wire logic        i_clock, i_rst, i_out_enable_n, i_sleep_request,
  input wire logic        o_sample_valid_strobe, o_powered_down,
  input wire logic [13:0] o_data, o_data_oe
);
  wire s = o_sample_valid_strobe;
  logic [2:0] r;
  always @(posedge i_clock) r <= {r[1:0], i_rst};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_sv_pulse: assert property (s |=> !s) else $error("wide strobe");
  a_sv_gap: assert property (s |=> !s[*5]) else $error("close strobes");
  a_word_hold: assert property (s |=> $stable(o_data)[*3]) else $error("word moved");
  a_oe_tie: assert property (r == 0 |->
    o_data_oe == {14{!$past(i_out_enable_n, 3)}}) else $error("bad enable");
  a_pd_tie: assert property (r == 0 |-> o_powered_down == $past(i_sleep_request, 3))
    else $error("bad sleep");
  a_pd_quiet: assert property (o_powered_down |-> !s) else $error("strobe asleep");
  a_wake_gap: assert property ($fell(o_powered_down) |-> !s[*8]) else $error("early");
  a_rst_clear: assert property (disable iff (1'b0) i_rst |=> !s && o_data_oe == 0)
    else $error("reset outputs");
  cover property (s);
  cover property (o_powered_down);
  cover property (o_data_oe == 0);
endmodule // pao_port_asserts
`default_nettype wire

//--- testbench/tb_pao_port.sv
// bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module tb_pao_port;
  logic i_clock = 0, i_rst = 1, i_convert_clock = 0, i_invert_input = 0;
  logic i_twos_comp_select = 0, i_out_enable_n = 0, i_sleep_request = 0;
  logic o_sample_valid_strobe, o_powered_down;
  logic [13:0] i_sample_true = 0, i_sample_comp = 0, o_data, o_data_oe, w;
  int fails = 0, n_checks = 0, t = 0;
  always #50 i_clock = ~i_clock;
  pao_port u_dut (.*);
  pao_capture u_cap (.*);
  task test_done;
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // runs take about 550 cycles
  always @(negedge i_clock) if (++t > 3000) begin
    fails++;
    test_done;
  end
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // sleep pulse, then twelve samples; the first two leave the pipeline
  task automatic run_block(input logic sel, input logic inv, input logic oe_n, input int base);
    logic [13:0] e;
    {i_twos_comp_select, i_invert_input, i_out_enable_n} = {sel, inv, oe_n};
    i_sleep_request = 1;
    repeat (6) @(negedge i_clock);
    check({13'h0000, o_powered_down}, 14'h0001);
    i_sleep_request = 0;
    repeat (4) @(negedge i_clock);
    check({13'h0000, o_powered_down}, 14'h0000);
    check(o_data_oe, oe_n ? 14'h0000 : 14'h3fff);
    for (int j = base; j < base + 12; j++) begin
      i_sample_true = j * 14'h0999;
      i_convert_clock = 1;
      repeat (4) @(negedge i_clock);
      i_convert_clock = 0;
      repeat (4) @(negedge i_clock);
      e = (j - 10) * 14'h0999;
      e = (inv ? -e : e) ^ {!sel, 13'h0000};
      if (j - base > 9) check(w, e);
    end
  endtask
  task automatic test_offset_true;
    run_block(1'b0, 1'b0, 1'b0, 0);
  endtask
  task automatic test_twos_inverted;
    run_block(1'b1, 1'b1, 1'b0, 12);
  endtask
  task automatic test_offset_floated;
    run_block(1'b0, 1'b1, 1'b1, 24);
  endtask
  task automatic test_twos_true;
    run_block(1'b1, 1'b0, 1'b0, 36);
  endtask
  task automatic test_reset_midrun;
    i_rst = 1;
    repeat (10) @(negedge i_clock);
    check(o_data_oe, 14'h0000);
    check({13'h0000, o_sample_valid_strobe}, 14'h0000);
    i_rst = 0;
    repeat (2) @(negedge i_clock);
    run_block(1'b0, 1'b0, 1'b0, 48);
  endtask
  initial begin
    repeat (10) @(negedge i_clock);
    i_rst = 0;
    test_offset_true;
    test_twos_inverted;
    test_offset_floated;
    test_twos_true;
    test_reset_midrun;
    test_done;
  end
endmodule // tb_pao_port
bind pao_port pao_port_asserts u_chk (.*);
`default_nettype wire
